// >>> logic/bcdpip_pkg.sv
`default_nettype none
package bcdpip_pkg;
	// register offsets on the local register port
	localparam logic [3:0] BINARY_MODE_SELECT_OFS = 4'h3;
	localparam logic [3:0] LINE_STATUS_OFS = 4'h4;
	localparam logic [3:0] FIRST_BYTE_OFS = 4'h5;
	localparam logic [3:0] LAST_BYTE_OFS = 4'h9;
	localparam logic [7:0] BINARY_MODE_RESET = 8'h00;
	// four-bit character codes inserted by the port
	localparam logic [3:0] CODE_LINE_FEED = 4'ha;
	localparam logic [3:0] CODE_PLUS = 4'hb;
	localparam logic [3:0] CODE_COMMA = 4'hc;
	localparam logic [3:0] CODE_MINUS = 4'hd;
	localparam logic [3:0] CODE_EXPONENT = 4'he;
	localparam logic [3:0] CODE_EIGHT = 4'h8;
	localparam logic [3:0] CODE_ZERO = 4'h0;
	// ascii values delivered to the host
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [7:0] ASCII_LINE_FEED = 8'h0a;
	localparam logic [7:0] ASCII_PLUS = 8'h2b;
	localparam logic [7:0] ASCII_COMMA = 8'h2c;
	localparam logic [7:0] ASCII_MINUS = 8'h2d;
	localparam logic [7:0] ASCII_EXPONENT = 8'h45;
	localparam logic [7:0] ASCII_UNKNOWN = 8'h3f;
	// characters per transfer, last index of each stream
	localparam logic [3:0] DECIMAL_LAST_INDEX = 4'hf;
	localparam logic [3:0] BINARY_LAST_INDEX = 4'h5;
	localparam logic [3:0] INDEX_RESET = 4'h0;
	localparam int DIGIT_GROUPS = 10;
	// sequencer states
	typedef enum logic [2:0] {
		BCDPIP_IDLE = 3'b001,
		BCDPIP_REQUEST = 3'b010,
		BCDPIP_STREAM = 3'b100
	} bcdpip_state_t;
endpackage
`default_nettype wire

// >>> logic/bcdpip_port.sv
// Operation
// - optional format starts a transfer by asserting both request lines
// - optional first number: first sign, then groups 4, 2, 6, 8
// - comma inserted after first device mantissa without reading lines
// - line feed inserted after second device fields, ending the transfer
// - second number: second sign, groups 10,1,5,3,7, exponent mark, two digits
// - overrange high reads 8 with sense on, inverted with sense off
// - data sense on treats digit lines as positive true
// - binary mode treats forty digit lines as five bytes, by handshake or status
// - binary mode ignores the format selection
// - non-zero write to binary_mode_select selects binary mode
// - binary mode requests data by setting the first request line
// - byte k holds odd group high nibble, even group low nibble
// - line feed follows the five binary bytes
`timescale 1ns/100ps
`default_nettype none
module bcdpip_port (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// peripheral lines, group one in the top nibble
	input wire logic [39:0] digit_groups_in,
	input wire logic first_sign_line_in,
	input wire logic second_sign_line_in,
	input wire logic overrange_line_in,
	input wire logic peripheral_flag_a_n_in,
	output logic request_line_a_n_out,
	output logic request_line_b_n_out,
	// peripheral status switches
	input wire logic format_select_switch_in,
	input wire logic data_sense_switch_in,
	input wire logic first_sign_switch_in,
	input wire logic second_sign_switch_in,
	input wire logic overrange_switch_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// transfer start and character stream
	input wire logic enter_start_in,
	output logic enter_busy_out,
	output logic char_valid_out,
	output logic [7:0] char_data_out,
	input wire logic char_ready_in
);
	bcdpip_pkg::bcdpip_state_t state_q, state_d;
	logic [7:0] binary_mode_q, binary_mode_d;
	logic [7:0] rdata_q, rdata_d;
	logic [39:0] groups_q, groups_d;
	logic [2:0] flags_q, flags_d;
	logic [3:0] index_q, index_d;
	logic req_a_q, req_a_d;
	logic req_b_q, req_b_d;
	logic binary_sel;
	logic optional_sel;
	logic [39:0] digits;
	logic [3:0] group [1:10];
	logic [3:0] sign1_code, sign2_code, ovl_code, g9_code;
	logic [3:0] dec_code;
	logic [7:0] stream_char;
	logic [3:0] last_index;
	logic push, buf_full;
	// buffer storage
	logic [7:0] buf_mem_q [0:1];
	logic [7:0] buf_mem_d [0:1];
	logic [1:0] buf_cnt_q, buf_cnt_d;
	logic buf_wp_q, buf_wp_d, buf_rp_q, buf_rp_d;

	// mode decode: binary overrides format switch
	assign binary_sel = binary_mode_q != 8'h00;
	assign optional_sel = !binary_sel && !format_select_switch_in;
	assign digits = data_sense_switch_in ? groups_q : ~groups_q;

	// split latched lines into ten groups
	genvar gi;
	generate
		for (gi = 1; gi <= bcdpip_pkg::DIGIT_GROUPS; gi++) begin : g_split
			assign group[gi] = digits[43 - 4 * gi -: 4];
		end
	endgenerate

	// sign and overrange characters
	assign sign1_code = (flags_q[2] == first_sign_switch_in) ? bcdpip_pkg::CODE_MINUS : bcdpip_pkg::CODE_PLUS;
	assign sign2_code = (flags_q[1] == second_sign_switch_in) ? bcdpip_pkg::CODE_MINUS : bcdpip_pkg::CODE_PLUS;
	assign ovl_code = (flags_q[0] == overrange_switch_in) ? bcdpip_pkg::CODE_EIGHT : bcdpip_pkg::CODE_ZERO;
	assign g9_code = group[9][3] ? bcdpip_pkg::CODE_EIGHT : bcdpip_pkg::CODE_ZERO;

	// map four-bit code to ascii
	function automatic logic [7:0] to_ascii(input logic [3:0] code);
		logic [7:0] c;
		c = bcdpip_pkg::ASCII_UNKNOWN;
		unique case (code)
			bcdpip_pkg::CODE_LINE_FEED: c = bcdpip_pkg::ASCII_LINE_FEED;
			bcdpip_pkg::CODE_PLUS: c = bcdpip_pkg::ASCII_PLUS;
			bcdpip_pkg::CODE_COMMA: c = bcdpip_pkg::ASCII_COMMA;
			bcdpip_pkg::CODE_MINUS: c = bcdpip_pkg::ASCII_MINUS;
			bcdpip_pkg::CODE_EXPONENT: c = bcdpip_pkg::ASCII_EXPONENT;
			4'hf: c = bcdpip_pkg::ASCII_UNKNOWN;
			default: c = bcdpip_pkg::ASCII_ZERO + {4'h0, code};
		endcase
		return c;
	endfunction

	// decimal character at the current index
	always_comb begin
		dec_code = bcdpip_pkg::CODE_LINE_FEED;
		if (optional_sel) begin
			unique case (index_q)
				4'h0: dec_code = sign1_code;
				4'h1: dec_code = group[4];
				4'h2: dec_code = group[2];
				4'h3: dec_code = group[6];
				4'h4: dec_code = group[8];
				4'h5: dec_code = bcdpip_pkg::CODE_COMMA;
				4'h6: dec_code = sign2_code;
				4'h7: dec_code = group[10];
				4'h8: dec_code = group[1];
				4'h9: dec_code = group[5];
				4'ha: dec_code = group[3];
				4'hb: dec_code = group[7];
				4'hc: dec_code = bcdpip_pkg::CODE_EXPONENT;
				4'hd: dec_code = ovl_code;
				4'he: dec_code = g9_code;
				4'hf: dec_code = bcdpip_pkg::CODE_LINE_FEED;
			endcase
		end else begin
			unique case (index_q)
				4'h0: dec_code = sign1_code;
				4'h1: dec_code = group[1];
				4'h2: dec_code = group[2];
				4'h3: dec_code = group[3];
				4'h4: dec_code = group[4];
				4'h5: dec_code = group[5];
				4'h6: dec_code = group[6];
				4'h7: dec_code = group[7];
				4'h8: dec_code = group[8];
				4'h9: dec_code = bcdpip_pkg::CODE_EXPONENT;
				4'ha: dec_code = sign2_code;
				4'hb: dec_code = group[9];
				4'hc: dec_code = bcdpip_pkg::CODE_COMMA;
				4'hd: dec_code = ovl_code;
				4'he: dec_code = group[10];
				4'hf: dec_code = bcdpip_pkg::CODE_LINE_FEED;
			endcase
		end
	end

	// stream character: packed bytes in binary mode, ascii otherwise
	always_comb begin
		stream_char = to_ascii(dec_code);
		last_index = bcdpip_pkg::DECIMAL_LAST_INDEX;
		if (binary_sel) begin
			last_index = bcdpip_pkg::BINARY_LAST_INDEX;
			if (index_q < bcdpip_pkg::BINARY_LAST_INDEX) begin
				stream_char = digits[39 - 8 * index_q -: 8];
			end else begin
				stream_char = bcdpip_pkg::ASCII_LINE_FEED;
			end
		end
	end

	assign buf_full = buf_cnt_q == 2'd2;
	assign push = (state_q == bcdpip_pkg::BCDPIP_STREAM) && !buf_full;

	// handshake and sequencer next state
	always_comb begin
		state_d = state_q;
		groups_d = groups_q;
		flags_d = flags_q;
		index_d = index_q;
		req_a_d = req_a_q;
		req_b_d = req_b_q;
		unique case (state_q)
			bcdpip_pkg::BCDPIP_IDLE: begin
				if (enter_start_in) begin
					req_a_d = 1'b1;
					req_b_d = optional_sel;
					index_d = bcdpip_pkg::INDEX_RESET;
					state_d = bcdpip_pkg::BCDPIP_REQUEST;
				end
			end
			bcdpip_pkg::BCDPIP_REQUEST: begin
				if (!peripheral_flag_a_n_in) begin
					groups_d = digit_groups_in;
					flags_d = {first_sign_line_in, second_sign_line_in, overrange_line_in};
					req_a_d = 1'b0;
					req_b_d = 1'b0;
					state_d = bcdpip_pkg::BCDPIP_STREAM;
				end
			end
			bcdpip_pkg::BCDPIP_STREAM: begin
				if (push) begin
					index_d = index_q + 4'h1;
					if (index_q == last_index) begin
						state_d = bcdpip_pkg::BCDPIP_IDLE;
					end
				end
			end
			default: begin
				state_d = bcdpip_pkg::BCDPIP_IDLE;
				req_a_d = 1'b0;
				req_b_d = 1'b0;
			end
		endcase
	end

	// two-entry character buffer next state
	always_comb begin
		buf_mem_d[0] = buf_mem_q[0];
		buf_mem_d[1] = buf_mem_q[1];
		buf_wp_d = buf_wp_q;
		buf_rp_d = buf_rp_q;
		buf_cnt_d = buf_cnt_q;
		if (push) begin
			buf_mem_d[buf_wp_q] = stream_char;
			buf_wp_d = !buf_wp_q;
		end
		if (char_valid_out && char_ready_in) begin
			buf_rp_d = !buf_rp_q;
		end
		buf_cnt_d = buf_cnt_q + {1'b0, push} - {1'b0, char_valid_out && char_ready_in};
	end

	// register port next state
	always_comb begin
		binary_mode_d = binary_mode_q;
		rdata_d = rdata_q;
		if (reg_wr_in && reg_addr_in == bcdpip_pkg::BINARY_MODE_SELECT_OFS) begin
			binary_mode_d = reg_wdata_in;
		end
		if (reg_rd_in) begin
			rdata_d = 8'h00;
			if (reg_addr_in == bcdpip_pkg::BINARY_MODE_SELECT_OFS) begin
				rdata_d = binary_mode_q;
			end else if (reg_addr_in == bcdpip_pkg::LINE_STATUS_OFS) begin
				rdata_d = {!format_select_switch_in, !data_sense_switch_in, !first_sign_switch_in,
					!second_sign_switch_in, !overrange_switch_in, flags_q};
			end else if (reg_addr_in >= bcdpip_pkg::FIRST_BYTE_OFS && reg_addr_in <= bcdpip_pkg::LAST_BYTE_OFS) begin
				rdata_d = digits[39 - 8 * (reg_addr_in - bcdpip_pkg::FIRST_BYTE_OFS) -: 8];
			end
		end
	end

	// registers
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= bcdpip_pkg::BCDPIP_IDLE;
			groups_q <= 40'h00_0000_0000;
			flags_q <= 3'h0;
			index_q <= bcdpip_pkg::INDEX_RESET;
			req_a_q <= 1'b0;
			req_b_q <= 1'b0;
			binary_mode_q <= bcdpip_pkg::BINARY_MODE_RESET;
			rdata_q <= 8'h00;
			buf_mem_q[0] <= 8'h00;
			buf_mem_q[1] <= 8'h00;
			buf_wp_q <= 1'b0;
			buf_rp_q <= 1'b0;
			buf_cnt_q <= 2'd0;
		end else begin
			state_q <= state_d;
			groups_q <= groups_d;
			flags_q <= flags_d;
			index_q <= index_d;
			req_a_q <= req_a_d;
			req_b_q <= req_b_d;
			binary_mode_q <= binary_mode_d;
			rdata_q <= rdata_d;
			buf_mem_q[0] <= buf_mem_d[0];
			buf_mem_q[1] <= buf_mem_d[1];
			buf_wp_q <= buf_wp_d;
			buf_rp_q <= buf_rp_d;
			buf_cnt_q <= buf_cnt_d;
		end
	end

	// outputs
	assign request_line_a_n_out = !req_a_q;
	assign request_line_b_n_out = !req_b_q;
	assign reg_rdata_out = rdata_q;
	assign enter_busy_out = state_q != bcdpip_pkg::BCDPIP_IDLE;
	assign char_valid_out = buf_cnt_q != 2'd0;
	assign char_data_out = buf_mem_q[buf_rp_q];
endmodule
`default_nettype wire

// >>> verification/bcdpip_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bcdpip_port_checker (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// handshake lines
	input wire logic peripheral_flag_a_n_in,
	input wire logic request_line_a_n_out,
	input wire logic request_line_b_n_out,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// transfer and stream
	input wire logic enter_start_in,
	input wire logic enter_busy_out,
	input wire logic char_valid_out,
	input wire logic [7:0] char_data_out,
	input wire logic char_ready_in
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// flag answered while the request is still low
	sequence s_hs;
		!request_line_a_n_out && !peripheral_flag_a_n_in;
	endsequence
	// the stream fills the buffer two edges on
	sequence s_first;
		##2 char_valid_out;
	endsequence
	property p_req_stand;
		!request_line_a_n_out && peripheral_flag_a_n_in |=> !request_line_a_n_out;
	endproperty
	property p_req_drop;
		s_hs |=> request_line_a_n_out && request_line_b_n_out;
	endproperty
	property p_first;
		s_hs |-> s_first;
	endproperty
	property p_b_with_a;
		!request_line_b_n_out |-> !request_line_a_n_out;
	endproperty
	property p_start;
		enter_start_in && !enter_busy_out |=> !request_line_a_n_out;
	endproperty
	property p_stall;
		char_valid_out && !char_ready_in |=> char_valid_out && $stable(char_data_out);
	endproperty
	property p_unmapped;
		reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out == 8'h00;
	endproperty
	property p_idle;
		!enter_busy_out |-> request_line_a_n_out && request_line_b_n_out;
	endproperty
	a_req_stand: assert property (p_req_stand) else $error("request dropped early");
	a_req_drop: assert property (p_req_drop) else $error("request held after flag");
	a_first: assert property (p_first) else $error("no character after handshake");
	a_b_with_a: assert property (p_b_with_a) else $error("second request alone");
	a_start: assert property (p_start) else $error("start gave no request");
	a_stall: assert property (p_stall) else $error("character lost in stall");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_idle: assert property (p_idle) else $error("request while idle");
endmodule
bind bcdpip_port bcdpip_port_checker bcdpip_port_checker_inst (.clock_in, .rstn_in, .peripheral_flag_a_n_in,
	.request_line_a_n_out, .request_line_b_n_out, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .enter_start_in,
	.enter_busy_out, .char_valid_out, .char_data_out, .char_ready_in);
`default_nettype wire

// >>> verification/bcdpip_peripheral_model.sv
`timescale 1ns/100ps
`default_nettype none
module bcdpip_peripheral_model (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// setup: digits, sign one, sign two, overrange
	input wire logic [42:0] value_in,
	input wire logic [3:0] delay_in,
	// lines toward the port
	input wire logic request_line_a_n_in,
	output logic [42:0] lines_out,
	output logic peripheral_flag_a_n_out
);
	logic [3:0] wait_q;
	// lines scramble while released, settle before the flag
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_q <= 4'h0;
			lines_out <= 43'h0;
			peripheral_flag_a_n_out <= 1'b1;
		end else if (request_line_a_n_in) begin
			wait_q <= 4'h0;
			lines_out <= ~lines_out;
			peripheral_flag_a_n_out <= 1'b1;
		end else if (wait_q <= delay_in) begin
			wait_q <= wait_q + 4'h1;
			lines_out <= (wait_q == delay_in) ? value_in : ~lines_out;
		end else begin
			peripheral_flag_a_n_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> verification/test_bcdpip_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_bcdpip_port;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [42:0] lines;
	logic [42:0] value = {40'h1234567880, 3'b101};
	logic [3:0] delay = 4'h0;
	logic [3:0] addr = 4'h0;
	logic flag_n, req_a_n, req_b_n, busy, valid;
	logic ready = 1'b0;
	logic fmt_sw = 1'b0;
	logic data_sw = 1'b1;
	logic sign_sw = 1'b1;
	logic ovl_sw = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic start = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, cdata;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	// port under test
	bcdpip_port bcdpip_port_inst (.clock_in(clock_in), .rstn_in(rstn_in), .digit_groups_in(lines[42:3]),
		.first_sign_line_in(lines[2]), .second_sign_line_in(lines[1]), .overrange_line_in(lines[0]),
		.peripheral_flag_a_n_in(flag_n), .request_line_a_n_out(req_a_n), .request_line_b_n_out(req_b_n),
		.format_select_switch_in(fmt_sw), .data_sense_switch_in(data_sw), .first_sign_switch_in(sign_sw),
		.second_sign_switch_in(sign_sw), .overrange_switch_in(ovl_sw), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .enter_start_in(start),
		.enter_busy_out(busy), .char_valid_out(valid), .char_data_out(cdata), .char_ready_in(ready));
	// far-side peripheral
	bcdpip_peripheral_model bcdpip_peripheral_model_inst (.clock_in(clock_in), .rstn_in(rstn_in),
		.value_in(value), .delay_in(delay), .request_line_a_n_in(req_a_n), .lines_out(lines),
		.peripheral_flag_a_n_out(flag_n));
	// clock and hang guard
	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			complete_run();
		end
	end
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task reg_write(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clock_in);
		wr = 1'b0;
	endtask
	task reg_check(input logic [3:0] a, input logic [7:0] exp);
		@(negedge clock_in);
		addr = a;
		rd = 1'b1;
		@(negedge clock_in);
		rd = 1'b0;
		@(negedge clock_in);
		check("register", rdata, exp);
	endtask
	// one transfer of len characters, right-aligned in s, then a line feed; receiver stalls every other cycle
	task xfer(input logic [127:0] s, input int len, input logic b_n);
		int n;
		logic [7:0] want;
		n = 0;
		@(negedge clock_in);
		start = 1'b1;
		@(negedge clock_in);
		start = 1'b0;
		@(negedge clock_in);
		check("busy", {7'h0, busy}, 8'h01);
		check("first request", {7'h0, req_a_n}, 8'h00);
		check("second request", {7'h0, req_b_n}, {7'h0, b_n});
		while (n <= len) begin
			@(negedge clock_in);
			if (!ready && valid) begin
				want = (n < len) ? s[8 * (len - 1 - n) +: 8] : bcdpip_pkg::ASCII_LINE_FEED;
				check("character", cdata, want);
				n++;
			end
			ready = ~ready;
		end
		// let the last character be taken before the receiver stalls again
		@(negedge clock_in);
		ready = 1'b0;
		check("busy", {7'h0, busy}, 8'h00);
	endtask
	task complete_run;
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(negedge clock_in);
		rstn_in = 1'b1;
		reg_check(4'h3, 8'h00);
		reg_check(4'h0, 8'h00);
		xfer("-4268,+01537E88", 15, 1'b0);
		data_sw = 1'b0;
		sign_sw = 1'b0;
		ovl_sw = 1'b0;
		value = {~40'h1234567880, 3'b010};
		delay = 4'h5;
		xfer("-4268,+01537E88", 15, 1'b0);
		for (int k = 0; k < 5; k++) begin
			reg_check(4'(5 + k), 8'(40'h1234567880 >> (32 - 8 * k)));
		end
		reg_check(4'h4, 8'hfa);
		// single-device format, only the first request line
		fmt_sw = 1'b1;
		xfer("-12345678E+8,80", 15, 1'b1);
		fmt_sw = 1'b0;
		reg_write(4'h3, 8'h80);
		reg_check(4'h3, 8'h80);
		xfer(40'h1234567880, 5, 1'b1);
		// reset after the binary transfer has ended returns to the decimal representation
		rstn_in = 1'b0;
		@(negedge clock_in);
		rstn_in = 1'b1;
		reg_check(4'h3, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
